// file: simd_fpu_consts.svh
`ifndef SIMD_FPU_CONSTS_SVH
`define SIMD_FPU_CONSTS_SVH

// Tag codes
`define TAG_VALID       2'h0
`define TAG_EMPTY       2'h3
// Stack top value after a packed-integer instruction
`define STACK_TOP_RESET 3'h0
// Exponent part of an aliased register
`define EXP_LSB         64
`define EXP_ONES        16'hffff
// Numeric, invalid-opcode and no-fault vectors
`define NUMERIC_VECTOR  8'h10
`define INV_OP_VECTOR   8'h06
`define NO_VECTOR       8'h00
// Prefix bytes
`define PFX_LOCK        8'hf0
`define PFX_ADDR        8'h67
`define PFX_OPSIZE      8'h66
`define PFX_REP         8'hf3
`define PFX_REPNE       8'hf2
`define PFX_CS          8'h2e
`define PFX_SS          8'h36
`define PFX_DS          8'h3e
`define PFX_ES          8'h26
`define PFX_FS          8'h64
`define PFX_GS          8'h65
// Segment selections
`define SEG_DEFAULT     3'h0
`define SEG_CS          3'h1
`define SEG_SS          3'h2
`define SEG_DS          3'h3
`define SEG_ES          3'h4
`define SEG_FS          3'h5
`define SEG_GS          3'h6

`endif

// file: simd_fpu_pkg.sv
package simd_fpu_pkg;

  // Instruction kind presented by the decoder
  typedef enum logic [2:0] {
    OP_NONE,
    OP_SIMD,
    OP_EMPTY_STATE,
    OP_FP_SAVE,
    OP_EXT_SAVE
  } op_kind_t;

  // One issued instruction
  typedef struct packed {
    op_kind_t    kind;
    logic [7:0]  prefix;
    logic        has_prefix;
    logic        has_mem;
    logic        writes_reg;
    logic [2:0]  reg_idx;
    logic [63:0] data;
  } instr_t;

  // Memory access status from the address path
  typedef struct packed {
    logic page_fault;
    logic seg_not_present;
    logic limit_violation;
  } mem_status_t;

  // Completion report
  typedef struct packed {
    logic       done;
    logic       fault;
    logic [7:0] vector;
    logic       restart;
  } result_t;

  typedef enum logic [1:0] {
    PFX_OK,
    PFX_INV_OP,
    PFX_RESERVED
  } pfx_class_t;

endpackage : simd_fpu_pkg

// file: prefix_check.sv
`timescale 1ns/100ps
`include "simd_fpu_consts.svh"

module prefix_check (
  // Prefix under test
  input  wire logic [7:0]               prefix,
  input  wire logic                     has_prefix,
  input  wire logic                     has_mem,
  // Classification
  output      simd_fpu_pkg::pfx_class_t pfx_class,
  output      logic                     addr_size_alt,
  output      logic [2:0]               seg_sel
);

  // Segment override decode, shared by class and selection
  function automatic logic [2:0] seg_of(input logic [7:0] p);
    unique case (p)
      `PFX_CS: seg_of = `SEG_CS;
      `PFX_SS: seg_of = `SEG_SS;
      `PFX_DS: seg_of = `SEG_DS;
      `PFX_ES: seg_of = `SEG_ES;
      `PFX_FS: seg_of = `SEG_FS;
      `PFX_GS: seg_of = `SEG_GS;
      default: seg_of = `SEG_DEFAULT;
    endcase
  endfunction : seg_of

  wire logic is_lock = has_prefix && prefix == `PFX_LOCK;
  wire logic is_addr = has_prefix && prefix == `PFX_ADDR;
  wire logic is_seg  = has_prefix && seg_of(prefix) != `SEG_DEFAULT;
  // Reserved-only prefixes; hint bytes share codes with segments
  wire logic is_resv = has_prefix && (prefix == `PFX_OPSIZE
                       || prefix == `PFX_REP || prefix == `PFX_REPNE);

  // Lock always faults; reserved ones fault too, the stricter choice
  assign pfx_class = is_lock ? simd_fpu_pkg::PFX_INV_OP
                   : is_resv ? simd_fpu_pkg::PFX_INV_OP
                   : ((is_addr || is_seg) && !has_mem)
                     ? simd_fpu_pkg::PFX_RESERVED
                   : simd_fpu_pkg::PFX_OK;
  assign addr_size_alt = is_addr && has_mem;
  assign seg_sel = (is_seg && has_mem) ? seg_of(prefix)
                                       : `SEG_DEFAULT;

endmodule : prefix_check

// file: simd_fpu_state.sv
`timescale 1ns/100ps
`include "simd_fpu_consts.svh"

// Functional notes
// - A packed-integer instruction other than the emptying one sets all tags to valid.
// - The emptying instruction marks the whole tag word empty.
// - The empty mark is code 11B in every tag field.
// - A packed-integer instruction other than the emptying one clears the stack top pointer.
// - A register write by a packed-integer instruction sets bits 64 to 79 to ones.
// - Both save instructions also store the packed-integer registers.
// - Each packed-integer register and tag lives in a floating-point register and tag.
// - Memory operands raise page, not-present and limit faults as any instruction.
// - No numeric exception comes from the instruction's own computation.
// - A pending floating-point exception raises vector 16 and the error output.
// - After the handler returns the faulting instruction restarts and runs normally.
// - A lock prefix raises the invalid-opcode fault.
// - The address-size prefix affects only instructions with a memory operand.
// - Segment overrides select the segment only for memory operands.
// - Operand-size, repeat and hint prefixes are reserved; here operand-size and repeat fault, hint bytes decode as segment overrides.
module simd_fpu_state #(
  parameter int NREGS = 8
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Instruction issue
  input  wire logic                      issue,
  input       simd_fpu_pkg::instr_t      instr,
  input       simd_fpu_pkg::mem_status_t mem_status,
  // Floating-point side
  input  wire logic                      fp_exc_pending,
  input  wire logic                      handler_return,
  // Completion and outputs
  output      simd_fpu_pkg::result_t     result,
  output      logic                      fp_error_out_n,
  output      logic [2*NREGS-1:0]        tag_word,
  output      logic [2:0]                stack_top_pointer,
  output      logic                      addr_size_alt,
  output      logic [2:0]                seg_sel,
  // State save stream
  output      logic                      save_valid,
  output      logic [79:0]               save_data
);

  // Index width of the shared register file
  localparam int IW = $clog2(NREGS);

  // Aliased storage: one array for both register views
  logic [79:0]         fpr_q [NREGS];
  logic [2*NREGS-1:0]  tag_q;
  logic [2:0]          top_q;
  logic                err_n_q;                            // Active low, as the pin
  simd_fpu_pkg::result_t res_q;
  logic                alt_q;
  logic [2:0]          seg_q;
  logic                sv_busy_q;
  logic [IW-1:0]       sv_idx_q;
  logic                sv_valid_q;
  logic [79:0]         sv_data_q;

  // Prefix check results
  simd_fpu_pkg::pfx_class_t pfx_class;
  logic                     alt_w;
  logic [2:0]               seg_w;

  // Prefix classification and address and segment selection
  prefix_check u_pfx (
    .prefix        (instr.prefix),
    .has_prefix    (instr.has_prefix),
    .has_mem       (instr.has_mem),
    .pfx_class     (pfx_class),
    .addr_size_alt (alt_w),
    .seg_sel       (seg_w)
  );

  // Kind match, shared by every decode below
  function automatic logic kind_is(input simd_fpu_pkg::op_kind_t k,
                                   input simd_fpu_pkg::op_kind_t want);
    kind_is = k == want;
  endfunction : kind_is

  // Decode of the issued instruction
  wire logic is_simd  = issue
                        && kind_is(instr.kind, simd_fpu_pkg::OP_SIMD);
  wire logic is_empty = issue
                        && kind_is(instr.kind, simd_fpu_pkg::OP_EMPTY_STATE);
  // A save during a walk is dropped; restarting would tear the stream
  wire logic is_save  = issue && !sv_busy_q
                        && (kind_is(instr.kind, simd_fpu_pkg::OP_FP_SAVE)
                         || kind_is(instr.kind, simd_fpu_pkg::OP_EXT_SAVE));
  wire logic pk_instr = is_simd || is_empty;
  wire logic inv_op_fault = pk_instr
                            && pfx_class == simd_fpu_pkg::PFX_INV_OP;
  // Memory faults arrive from the shared address path as for any op
  wire logic mem_fault = is_simd && instr.has_mem
                         && (mem_status.page_fault
                          || mem_status.seg_not_present
                          || mem_status.limit_violation);
  // Only an already pending exception can raise a numeric error
  wire logic num_fault = pk_instr && !inv_op_fault && !mem_fault
                         && fp_exc_pending;
  // Any fault blocks the whole commit, so no partial update of tags,
  // stack top or register is ever left behind
  wire logic any_fault = inv_op_fault || mem_fault || num_fault;
  wire logic commit_simd  = is_simd && !any_fault;
  wire logic commit_empty = is_empty && !any_fault;

  // Fault vector priority: prefix, memory, numeric; a memory fault
  // carries no vector here, the existing fault path supplies it
  wire logic [7:0] vec_w = inv_op_fault ? `INV_OP_VECTOR
                         : num_fault    ? `NUMERIC_VECTOR
                         : `NO_VECTOR;

  // Tag word next value, one field beside each aliased register
  logic [2*NREGS-1:0] tag_d;

  for (genvar r = 0; r < NREGS; r++) begin : g_tag
    assign tag_d[2*r +: 2] = commit_empty ? `TAG_EMPTY
                           : commit_simd  ? `TAG_VALID
                           : tag_q[2*r +: 2];
  end

  // Stack top next value, cleared by a committed packed op other than the emptying one
  wire logic [2:0] top_d = commit_simd ? `STACK_TOP_RESET : top_q;

  // Register write: data plus all-ones exponent, same commit edge
  // Forcing the exponent keeps the floating-point view from ever
  // seeing an old exponent under new packed data
  wire logic [79:0] wr_val = {`EXP_ONES, instr.data};
  wire logic        wr_en  = commit_simd && instr.writes_reg;

  // Aliased register file
  // No per-view copy exists: both views read this one array
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NREGS; i++) begin
        fpr_q[i] <= '0;
      end
    end else if (wr_en) begin
      fpr_q[instr.reg_idx[IW-1:0]] <= wr_val;
    end
  end

  // Architectural state commit
  // Tags and stack top move on the same edge as the register write
  always_ff @(posedge clk) begin
    if (rst) begin
      tag_q <= {NREGS{`TAG_EMPTY}};
      top_q <= `STACK_TOP_RESET;
    end else begin
      tag_q <= tag_d;
      top_q <= top_d;
    end
  end

  // Error pin held low while the handler runs; a new error beats the
  // return in the same cycle, so a fresh exception is never lost
  wire logic err_n_d = num_fault      ? 1'b0
                     : handler_return ? 1'b1
                     : err_n_q;

  // Pin register resets released, so no false error after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      err_n_q <= 1'b1;
    end else begin
      err_n_q <= err_n_d;
    end
  end

  // Completion report, one cycle after issue
  // Address and segment outputs follow packed instructions other than the emptying
  // one; every other cycle returns them to the default
  always_ff @(posedge clk) begin
    if (rst) begin
      res_q <= '0;
      alt_q <= 1'b0;
      seg_q <= `SEG_DEFAULT;
    end else begin
      res_q.done    <= pk_instr;
      res_q.fault   <= any_fault;
      res_q.vector  <= vec_w;
      res_q.restart <= num_fault;
      alt_q         <= is_simd ? alt_w : 1'b0;
      seg_q         <= is_simd ? seg_w : `SEG_DEFAULT;
    end
  end

  // Save walk over the shared registers, one word per cycle
  // The walk reads the live array, so a packed write during a walk
  // may already show in words not yet sent
  wire logic sv_last = sv_idx_q == IW'(NREGS - 1);

  always_ff @(posedge clk) begin
    if (rst) begin
      sv_busy_q  <= 1'b0;
      sv_idx_q   <= '0;
      sv_valid_q <= 1'b0;
      sv_data_q  <= '0;
    end else begin
      sv_valid_q <= sv_busy_q;
      sv_data_q  <= sv_busy_q ? fpr_q[sv_idx_q] : '0;
      if (is_save) begin
        sv_busy_q <= 1'b1;
        sv_idx_q  <= '0;
      end else if (sv_busy_q) begin
        sv_busy_q <= !sv_last;
        sv_idx_q  <= sv_last ? '0 : IW'(sv_idx_q + 1'b1);
      end
    end
  end

  // Outputs straight from flip-flops
  // The error pin register already holds the active-low level
  assign result            = res_q;
  assign fp_error_out_n    = err_n_q;
  assign tag_word          = tag_q;
  assign stack_top_pointer = top_q;
  assign addr_size_alt     = alt_q;
  assign seg_sel           = seg_q;
  assign save_valid        = sv_valid_q;
  assign save_data         = sv_data_q;

endmodule : simd_fpu_state

// file: simd_fpu_monitor.sv
`timescale 1ns/100ps
module simd_fpu_monitor #(
  parameter int NREGS = 8
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Issue side
  input  wire logic                      issue,
  input       simd_fpu_pkg::instr_t      instr,
  input       simd_fpu_pkg::mem_status_t mem_status,
  input  wire logic                      fp_exc_pending,
  input  wire logic                      handler_return,
  // Watched outputs
  input       simd_fpu_pkg::result_t     result,
  input  wire logic                      fp_error_out_n,
  input  wire logic [2*NREGS-1:0]        tag_word,
  input  wire logic [2:0]                stack_top_pointer
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Issue classes; bare means no prefix and no memory fault
  wire simd = issue && instr.kind == simd_fpu_pkg::OP_SIMD;
  wire bare = !instr.has_prefix && !(|mem_status);
  wire lock = instr.has_prefix && instr.prefix == 8'hf0;
  wire empt = issue && instr.kind == simd_fpu_pkg::OP_EMPTY_STATE;
  // Deferred error: taken, then pin held low
  sequence pend_hit;
    simd && bare && fp_exc_pending;
  endsequence
  sequence pin_low;
    !fp_error_out_n;
  endsequence
  tags_valid_a: assert property (
    simd && bare && !fp_exc_pending |=> tag_word == '0)
    else $error("tags not valid after packed op");
  top_clear_a: assert property (
    simd && bare && !fp_exc_pending |=> stack_top_pointer == 3'h0 && result.done)
    else $error("stack top not cleared with completion");
  tags_empty_a: assert property (
    empt && bare && !fp_exc_pending |=> tag_word == '1)
    else $error("tags not empty after empty op");
  numeric_err_a: assert property (
    pend_hit |=> (result.fault && result.vector == 8'h10) ##0 pin_low)
    else $error("pending error not raised");
  no_numeric_a: assert property (
    simd && !fp_exc_pending |=> result.vector != 8'h10)
    else $error("numeric vector without pending error");
  pin_hold_a: assert property (
    pin_low and !handler_return |=> pin_low)
    else $error("error pin released early");
  pin_release_a: assert property (
    handler_return && !issue |=> fp_error_out_n)
    else $error("error pin not released");
  lock_fault_a: assert property (
    simd && lock |=> result.fault && result.vector == 8'h06 && $stable(tag_word))
    else $error("lock prefix not refused");
  mem_fault_a: assert property (
    simd && !instr.has_prefix && instr.has_mem && |mem_status
    |=> result.fault && result.vector == 8'h00)
    else $error("memory fault not raised");
  reserved_fault_a: assert property (
    simd && instr.has_prefix && (instr.prefix == 8'h66
    || instr.prefix == 8'hf3 || instr.prefix == 8'hf2)
    |=> result.fault && result.vector == 8'h06)
    else $error("reserved prefix not refused");
endmodule : simd_fpu_monitor

bind simd_fpu_state simd_fpu_monitor #(.NREGS(NREGS)) mon (
  .clk(clk), .rst(rst), .issue(issue), .instr(instr),
  .mem_status(mem_status), .fp_exc_pending(fp_exc_pending),
  .handler_return(handler_return), .result(result),
  .fp_error_out_n(fp_error_out_n), .tag_word(tag_word),
  .stack_top_pointer(stack_top_pointer));

// file: simd_fpu_state_bench.sv
`timescale 1ns/100ps
module simd_fpu_state_bench;
  localparam int NREGS = 8;
  // Driven inputs
  logic                      clk = 0;
  logic                      rst = 1;
  logic                      issue = 0;
  simd_fpu_pkg::instr_t      instr = '0;
  simd_fpu_pkg::mem_status_t mem_status = '0;
  logic                      fp_exc_pending = 0;
  logic                      handler_return = 0;
  // Observed outputs
  simd_fpu_pkg::result_t     result;
  logic                      fp_error_out_n;
  logic [2*NREGS-1:0]        tag_word;
  logic [2:0]                stack_top_pointer;
  logic                      addr_size_alt;
  logic [2:0]                seg_sel;
  logic                      save_valid;
  logic [79:0]               save_data;
  int                        mismatches = 0;
  int                        comparisons = 0;

  simd_fpu_state #(.NREGS(NREGS)) dut (.clk(clk), .rst(rst),
    .issue(issue), .instr(instr), .mem_status(mem_status),
    .fp_exc_pending(fp_exc_pending), .handler_return(handler_return),
    .result(result), .fp_error_out_n(fp_error_out_n),
    .tag_word(tag_word), .stack_top_pointer(stack_top_pointer),
    .addr_size_alt(addr_size_alt), .seg_sel(seg_sel),
    .save_valid(save_valid), .save_data(save_data));

  // 50 ns clock
  initial forever #25 clk = ~clk;

  task automatic chk(string what, logic [79:0] seen, logic [79:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // One issue; returns with the answer settled
  task automatic op(simd_fpu_pkg::op_kind_t k, logic [7:0] p, logic hp,
                    logic m);
    @(posedge clk);
    instr <= '{k, p, hp, m, 1'b1, 3'h3, 64'h0123_4567_89ab_cdef};
    issue <= 1;
    @(posedge clk);
    issue <= 0;
    #1;
  endtask : op

  // Save walk; register 3 holds the last write
  task automatic save_chk(simd_fpu_pkg::op_kind_t k);
    int n = 0;
    op(k, 8'h00, 1'b0, 1'b0);
    repeat (NREGS + 2) begin
      @(posedge clk);
      #1;
      if (save_valid === 1'b1) begin
        if (n == 3) chk("save3", save_data, 80'hffff_0123_4567_89ab_cdef);
        n++;
      end
    end
    chk("words", n, NREGS);
  endtask : save_chk

  task automatic t_simd;
    @(posedge clk);
    #1;
    chk("rst tag", tag_word, 16'hffff);
    op(simd_fpu_pkg::OP_SIMD, 8'h00, 1'b0, 1'b0);
    chk("done", result.done, 1'b1);
    chk("tag", tag_word, 16'h0000);
    chk("top", stack_top_pointer, 3'h0);
    save_chk(simd_fpu_pkg::OP_FP_SAVE);
    save_chk(simd_fpu_pkg::OP_EXT_SAVE);
  endtask : t_simd

  // Lock and reserved prefixes refuse and leave tags empty
  task automatic t_prefix;
    logic [7:0] bad_pfx[4] = '{8'hf0, 8'h66, 8'hf3, 8'hf2};
    logic [7:0] sg[6] = '{8'h2e, 8'h36, 8'h3e, 8'h26, 8'h64, 8'h65};
    op(simd_fpu_pkg::OP_EMPTY_STATE, 8'h00, 1'b0, 1'b0);
    chk("empty", tag_word, 16'hffff);
    foreach (bad_pfx[i]) begin
      op(simd_fpu_pkg::OP_SIMD, bad_pfx[i], 1'b1, 1'b0);
      chk("refused", {result.fault, result.vector}, 9'h106);
      chk("refused tag", tag_word, 16'hffff);
    end
    foreach (sg[i]) begin
      op(simd_fpu_pkg::OP_SIMD, sg[i], 1'b1, 1'b1);
      chk("seg", seg_sel, i + 1);
    end
    op(simd_fpu_pkg::OP_SIMD, 8'h67, 1'b1, 1'b1);
    chk("asz", addr_size_alt, 1'b1);
    op(simd_fpu_pkg::OP_SIMD, 8'h67, 1'b1, 1'b0);
    chk("asz nomem", {result.fault, addr_size_alt}, 2'h0);
    op(simd_fpu_pkg::OP_SIMD, 8'h2e, 1'b1, 1'b0);
    chk("seg nomem", {result.fault, seg_sel}, 4'h0);
  endtask : t_prefix

  task automatic t_mem;
    op(simd_fpu_pkg::OP_EMPTY_STATE, 8'h00, 1'b0, 1'b0);
    for (int b = 0; b < 3; b++) begin
      @(posedge clk);
      mem_status <= 3'h1 << b;
      op(simd_fpu_pkg::OP_SIMD, 8'h00, 1'b0, 1'b1);
      chk("memf", {result.fault, result.vector}, 9'h100);
      chk("memf tag", tag_word, 16'hffff);
    end
    @(posedge clk);
    mem_status <= '0;
  endtask : t_mem

  // Deferred error, handler return, then restart
  task automatic t_numeric;
    @(posedge clk);
    fp_exc_pending <= 1;
    op(simd_fpu_pkg::OP_SIMD, 8'h00, 1'b0, 1'b0);
    chk("num", {result.fault, result.vector, result.restart}, 10'h221);
    repeat (3) @(posedge clk);
    #1;
    chk("pin", fp_error_out_n, 1'b0);
    @(posedge clk);
    fp_exc_pending <= 0;
    handler_return <= 1;
    @(posedge clk);
    handler_return <= 0;
    #1;
    chk("pin up", fp_error_out_n, 1'b1);
    op(simd_fpu_pkg::OP_SIMD, 8'h00, 1'b0, 1'b0);
    chk("rerun", {result.fault, tag_word}, 17'h0_0000);
  endtask : t_numeric

  // Watchdog
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    t_simd();
    t_prefix();
    t_mem();
    t_numeric();
    end_sim();
  end
endmodule : simd_fpu_state_bench
